// file: rtl/bit_test_set_unit.v
// decode and execution of bit test through index_y and the bit set forms
// assumes opcode bytes arrive one per fetch strobe; memory answers reads
// on mem_rd_data_in in the cycle after mem_rd_out
//
// Function
// - index_y test reads index_y plus displacement
// - test sets null flag from bit
// - test never writes the memory byte
// - bit zero is least significant
// - bit field is plain binary index
// - register field codes, 110 is none
// - register set forces one bit only
// - pointer set targets pointer_pair byte
// - index_x set adds signed displacement
// - index_y order FD, CB, d, op
// - set forms keep all flags
// - indexed set takes 23 states
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "bit_test_set_consts.vh"
module bit_test_set_unit (
  // clock and reset
  input  wire        core_clk_in,
  input  wire        rst_b_in,
  // fetch path
  input  wire        fetch_vld_in,
  input  wire [7:0]  fetch_byte_in,
  output reg         fetch_rdy_out,
  // address registers
  input  wire [15:0] index_x_in,
  input  wire [15:0] index_y_in,
  input  wire [15:0] pointer_pair_in,
  // memory bus
  output reg  [15:0] mem_addr_out,
  output reg         mem_rd_out,
  output reg         mem_wr_out,
  output reg  [7:0]  mem_wr_data_out,
  input  wire [7:0]  mem_rd_data_in,
  // register read and write port
  input  wire [7:0]  gpr_rd_data_in,
  output reg  [2:0]  gpr_sel_out,
  output reg         gpr_wr_out,
  output reg  [7:0]  gpr_wr_data_out,
  // status
  input  wire [7:0]  status_byte_in,
  output reg  [7:0]  status_byte_reg_out,
  output reg         status_wr_out,
  output reg         done_out
);
  localparam S_IDLE = 3'h0;
  localparam S_PFX  = 3'h1;
  localparam S_DISP = 3'h2;
  localparam S_OP   = 3'h3;
  localparam S_WAIT = 3'h4;
  localparam S_RD   = 3'h5;
  localparam S_WR   = 3'h6;
  localparam S_END  = 3'h7;

  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [1:0]  idx_ff;
  reg [1:0]  nxt_idx;
  reg [7:0]  disp_ff;
  reg [7:0]  nxt_disp;
  reg [7:0]  op_ff;
  reg [7:0]  nxt_op;
  reg [4:0]  cnt_ff;
  reg [4:0]  nxt_cnt;
  reg [15:0] nxt_addr;
  reg        nxt_rd;
  reg        nxt_wr;
  reg [7:0]  nxt_wdata;
  reg [2:0]  nxt_gsel;
  reg        nxt_gwr;
  reg [7:0]  nxt_gdata;
  reg [7:0]  nxt_status;
  reg        nxt_swr;
  reg        nxt_done;
  reg        nxt_rdy;

  wire [7:0] operand;
  wire [7:0] set_val;
  wire       bit_val;
  wire       is_test;
  wire       is_mem;

  // sign-extended displacement add
  function [15:0] index_sum;
    input [15:0] base;
    input [7:0]  d;
    begin
      index_sum = base + {{8{d[7]}}, d};
    end
  endfunction

  // idx_ff: 0 none, 1 index_x, 2 index_y
  assign operand = (state_ff == S_RD) ? mem_rd_data_in : gpr_rd_data_in;
  assign is_test = (op_ff[7:6] == `OP_GRP_TEST);
  assign is_mem  = (op_ff[2:0] == `REG_CODE_MEM);

  bit_select u_sel (
    .data_in (operand),
    .sel_in  (op_ff[5:3]),
    .set_out (set_val),
    .bit_out (bit_val)
  );

  always @* begin
    nxt_state  = state_ff;
    nxt_idx    = idx_ff;
    nxt_disp   = disp_ff;
    nxt_op     = op_ff;
    nxt_cnt    = cnt_ff;
    nxt_addr   = mem_addr_out;
    nxt_rd     = 1'b0;
    nxt_wr     = 1'b0;
    nxt_wdata  = mem_wr_data_out;
    nxt_gsel   = gpr_sel_out;
    nxt_gwr    = 1'b0;
    nxt_gdata  = gpr_wr_data_out;
    nxt_status = status_byte_reg_out;
    nxt_swr    = 1'b0;
    nxt_done   = 1'b0;
    nxt_rdy    = fetch_rdy_out;
    if (cnt_ff != 5'h00)
      nxt_cnt = cnt_ff - 5'h01;
    case (state_ff)
      S_IDLE: begin
        nxt_rdy = 1'b1;
        if (fetch_vld_in && fetch_rdy_out) begin
          nxt_cnt = 5'h01;
          if (fetch_byte_in == `PFX_CB) begin
            nxt_idx   = 2'h0;
            nxt_state = S_OP;
          end else if (fetch_byte_in == `PFX_INDEX_X) begin
            nxt_idx   = 2'h1;
            nxt_state = S_PFX;
          end else if (fetch_byte_in == `PFX_INDEX_Y) begin
            nxt_idx   = 2'h2;
            nxt_state = S_PFX;
          end
        end
      end
      S_PFX: begin
        if (fetch_vld_in && fetch_rdy_out)
          nxt_state = (fetch_byte_in == `PFX_CB) ? S_DISP : S_IDLE;
      end
      S_DISP: begin
        if (fetch_vld_in && fetch_rdy_out) begin
          nxt_disp  = fetch_byte_in;
          nxt_state = S_OP;
        end
      end
      S_OP: begin
        if (fetch_vld_in && fetch_rdy_out) begin
          nxt_op   = fetch_byte_in;
          nxt_rdy  = 1'b0;
          nxt_gsel = fetch_byte_in[2:0];
          nxt_state = S_IDLE;
          if (fetch_byte_in[7:6] == `OP_GRP_SET) begin
            nxt_state = S_WAIT;
            if (idx_ff == 2'h0 && fetch_byte_in[2:0] != `REG_CODE_MEM)
              nxt_cnt = `STATES_REG - 5'h01;
            else if (idx_ff == 2'h0)
              nxt_cnt = `STATES_PTR - 5'h01;
            else
              nxt_cnt = `STATES_IDX - 5'h03;
          end else if (fetch_byte_in[7:6] == `OP_GRP_TEST && idx_ff == 2'h2 &&
                       fetch_byte_in[2:0] == `REG_CODE_MEM) begin
            nxt_state = S_WAIT;
            nxt_cnt   = `STATES_TEST_Y - 5'h03;
          end else begin
            nxt_rdy = 1'b1;
          end
          if (nxt_state == S_WAIT) begin
            if (fetch_byte_in[2:0] == `REG_CODE_MEM) begin
              if (idx_ff == 2'h1)
                nxt_addr = index_sum(index_x_in, disp_ff);
              else if (idx_ff == 2'h2)
                nxt_addr = index_sum(index_y_in, disp_ff);
              else
                nxt_addr = pointer_pair_in;
            end
          end
        end
      end
      S_WAIT: begin
        if (is_mem) begin
          // read before write
          // read data arrive one cycle after the strobe
          if (cnt_ff == 5'h05)
            nxt_rd = 1'b1;
          else if (cnt_ff == 5'h04)
            nxt_state = S_RD;
        end else if (cnt_ff == 5'h03) begin
          nxt_gdata = set_val;
          nxt_gwr   = 1'b1;
          nxt_state = S_END;
        end
      end
      S_RD: begin
        if (is_test) begin
          nxt_status = status_byte_in;
          nxt_status[`FLAG_NULL]    = ~bit_val;
          nxt_status[`FLAG_NIBBLE]  = 1'b1;
          nxt_status[`FLAG_SUB]     = 1'b0;
          nxt_swr   = 1'b1;
          nxt_state = S_END;
        end else begin
          nxt_wdata = set_val;
          nxt_wr    = 1'b1;
          nxt_state = S_WR;
        end
      end
      S_WR: begin
        nxt_state = S_END;
      end
      S_END: begin
        if (cnt_ff <= 5'h01) begin
          nxt_done  = 1'b1;
          nxt_rdy   = 1'b1;
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff            <= S_IDLE;
      idx_ff              <= 2'h0;
      disp_ff             <= `REG_RESET;
      op_ff               <= `REG_RESET;
      cnt_ff              <= 5'h00;
      mem_addr_out        <= 16'h0000;
      mem_rd_out          <= 1'b0;
      mem_wr_out          <= 1'b0;
      mem_wr_data_out     <= `REG_RESET;
      gpr_sel_out         <= 3'h0;
      gpr_wr_out          <= 1'b0;
      gpr_wr_data_out     <= `REG_RESET;
      status_byte_reg_out <= `REG_RESET;
      status_wr_out       <= 1'b0;
      done_out            <= 1'b0;
      fetch_rdy_out       <= 1'b0;
    end else begin
      state_ff            <= nxt_state;
      idx_ff              <= nxt_idx;
      disp_ff             <= nxt_disp;
      op_ff               <= nxt_op;
      cnt_ff              <= nxt_cnt;
      mem_addr_out        <= nxt_addr;
      mem_rd_out          <= nxt_rd;
      mem_wr_out          <= nxt_wr;
      mem_wr_data_out     <= nxt_wdata;
      gpr_sel_out         <= nxt_gsel;
      gpr_wr_out          <= nxt_gwr;
      gpr_wr_data_out     <= nxt_gdata;
      status_byte_reg_out <= nxt_status;
      status_wr_out       <= nxt_swr;
      done_out            <= nxt_done;
      fetch_rdy_out       <= nxt_rdy;
    end
  end
endmodule // bit_test_set_unit

// file: rtl/bit_test_set_consts.vh
// constants for the single-bit test and set instruction unit
// assumes one core clock; each state count is one clock of core_clk_in
`ifndef BIT_TEST_SET_CONSTS_VH
`define BIT_TEST_SET_CONSTS_VH
`define PFX_CB        8'hcb
`define PFX_INDEX_X   8'hdd
`define PFX_INDEX_Y   8'hfd
`define OP_GRP_SET    2'h3
`define OP_GRP_TEST   2'h1
`define REG_CODE_MEM  3'h6
`define FLAG_NEG      7
`define FLAG_NULL     6
`define FLAG_NIBBLE   4
`define FLAG_PAR      2
`define FLAG_SUB      1
`define FLAG_CARRY    0
`define STATES_REG    5'h08
`define STATES_PTR    5'h0f
`define STATES_IDX    5'h17
`define STATES_TEST_Y 5'h14
`define REG_RESET     8'h00
`endif

// file: rtl/bit_select.v
// bit mask and bit pick for a 3-bit binary bit index
// assumes bit 0 is the least significant bit
module bit_select (
  // operand
  input  wire [7:0] data_in,
  input  wire [2:0] sel_in,
  // results
  output wire [7:0] set_out,
  output wire       bit_out
);
  wire [7:0] mask;
  assign mask    = 8'h01 << sel_in;
  assign bit_out = |(data_in & mask);
  assign set_out = data_in | mask;
endmodule // bit_select

// file: tb/bit_test_set_unit_monitor.sv
// checker bound to the bit test and set unit ports
// assumes gpr_rd_data_in shows the register picked by gpr_sel_out
`include "bit_test_set_consts.vh"
module bit_test_set_unit_monitor (
  // clock, reset and fetch
  input wire        core_clk_in,
  input wire        rst_b_in,
  input wire        fetch_vld_in,
  input wire [7:0]  fetch_byte_in,
  input wire        fetch_rdy_out,
  // memory, registers, flags
  input wire [15:0] mem_addr_out,
  input wire        mem_rd_out,
  input wire        mem_wr_out,
  input wire [7:0]  mem_wr_data_out,
  input wire [7:0]  mem_rd_data_in,
  input wire [7:0]  gpr_rd_data_in,
  input wire [2:0]  gpr_sel_out,
  input wire        gpr_wr_out,
  input wire [7:0]  gpr_wr_data_out,
  input wire [7:0]  status_byte_reg_out,
  input wire        status_wr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  op_ff;
  logic [7:0]  rd_ff;
  logic [15:0] ra_ff;
  logic        rd_d_ff;
  logic        tst_ff;
  wire  [7:0]  msk = 8'h01 << op_ff[5:3];
  // last opcode byte and last read byte and address
  always @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      op_ff <= 8'h00;
      rd_ff <= 8'h00;
      ra_ff <= 16'h0000;
      rd_d_ff <= 1'b0;
      tst_ff <= 1'b0;
    end else begin
      rd_d_ff <= mem_rd_out;
      if (rd_d_ff) rd_ff <= mem_rd_data_in;
      if (mem_rd_out) ra_ff <= mem_addr_out;
      if (fetch_vld_in && fetch_rdy_out) op_ff <= fetch_byte_in;
      if (fetch_vld_in && fetch_rdy_out) tst_ff <= fetch_byte_in[7:6] == `OP_GRP_TEST;
    end
  end
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_wr_addr; mem_wr_out |-> mem_addr_out == ra_ff; endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address not read address");
  property p_wr_data; mem_wr_out |-> mem_wr_data_out == (rd_ff | msk); endproperty
  a_wr_data: assert property (p_wr_data) else $error("bad memory write data");
  property p_gpr_data; gpr_wr_out |-> gpr_wr_data_out == (gpr_rd_data_in | msk); endproperty
  a_gpr_data: assert property (p_gpr_data) else $error("bad register write data");
  property p_gpr_sel; gpr_wr_out |-> gpr_sel_out == op_ff[2:0] && op_ff[2:0] != 3'h6; endproperty
  a_gpr_sel: assert property (p_gpr_sel) else $error("bad register select");
  property p_set_flags; status_wr_out |-> tst_ff; endproperty
  a_set_flags: assert property (p_set_flags) else $error("set wrote flags");
  property p_tst_flags; status_wr_out |-> status_byte_reg_out[4] && !status_byte_reg_out[1]; endproperty
  a_tst_flags: assert property (p_tst_flags) else $error("bad test flags");
  property p_tst_null; status_wr_out |-> status_byte_reg_out[6] == !(|(rd_ff & msk)); endproperty
  a_tst_null: assert property (p_tst_null) else $error("bad null flag");
  property p_tst_nowr; tst_ff |-> !mem_wr_out; endproperty
  a_tst_nowr: assert property (p_tst_nowr) else $error("test wrote memory");
  c_tst: cover property (status_wr_out);
  c_mem: cover property (mem_wr_out);
  c_gpr: cover property (gpr_wr_out);
endmodule // bit_test_set_unit_monitor
bind bit_test_set_unit bit_test_set_unit_monitor u_mon (.core_clk_in, .rst_b_in, .fetch_vld_in,
  .fetch_byte_in, .fetch_rdy_out, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wr_data_out,
  .mem_rd_data_in, .gpr_rd_data_in, .gpr_sel_out, .gpr_wr_out, .gpr_wr_data_out,
  .status_byte_reg_out, .status_wr_out);

// file: tb/bit_test_set_mem_model.sv
// memory on the far side of the unit's memory bus
// assumes one strobe per cycle, read data in the next cycle
module bit_test_set_mem_model (
  // memory bus
  input  wire        core_clk_in,
  input  wire [15:0] mem_addr_out,
  input  wire        mem_rd_out,
  input  wire        mem_wr_out,
  input  wire [7:0]  mem_wr_data_out,
  output logic [7:0] mem_rd_data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  initial mem_rd_data_in = 8'h5a;
  // idle bus shows changing data
  always @(posedge core_clk_in) begin
    if (mem_rd_out) mem_rd_data_in <= mem[mem_addr_out];
    else mem_rd_data_in <= ~mem_rd_data_in;
    if (mem_wr_out) mem[mem_addr_out] <= mem_wr_data_out;
  end
endmodule // bit_test_set_mem_model

// file: tb/bit_test_set_unit_tb.sv
// self-checking bench for the bit test and set unit
// assumes the memory model beside it and the bound checker
`include "bit_test_set_consts.vh"
module bit_test_set_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_in, rst_b_in, fetch_vld_in;
  logic [7:0]  fetch_byte_in, status_byte_in, st, pre;
  logic [15:0] index_x_in, index_y_in, pointer_pair_in, ea;
  logic [7:0]  regs [0:7];
  wire         fetch_rdy_out, mem_rd_out, mem_wr_out, gpr_wr_out, status_wr_out, done_out;
  wire  [15:0] mem_addr_out;
  wire  [7:0]  mem_wr_data_out, mem_rd_data_in, gpr_wr_data_out, status_byte_reg_out;
  wire  [2:0]  gpr_sel_out;
  wire  [7:0]  gpr_rd_data_in = regs[gpr_sel_out];
  int          error_cnt, n_checks, k, k0, j;
  bit_test_set_unit dut (.core_clk_in, .rst_b_in, .fetch_vld_in, .fetch_byte_in, .fetch_rdy_out,
    .index_x_in, .index_y_in, .pointer_pair_in, .mem_addr_out, .mem_rd_out, .mem_wr_out,
    .mem_wr_data_out, .mem_rd_data_in, .gpr_rd_data_in, .gpr_sel_out, .gpr_wr_out,
    .gpr_wr_data_out, .status_byte_in, .status_byte_reg_out, .status_wr_out, .done_out);
  bit_test_set_mem_model mdl (.core_clk_in, .mem_addr_out, .mem_rd_out, .mem_wr_out,
    .mem_wr_data_out, .mem_rd_data_in);
  always @(posedge core_clk_in) if (gpr_wr_out) regs[gpr_sel_out] <= gpr_wr_data_out;
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end
  task automatic end_sim();
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    fetch_vld_in <= 1'b1;
    fetch_byte_in <= b;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (fetch_rdy_out !== 1'b1 && k < 99);
  endtask
  // kind 0 register, 1 pointer, 2 index_x, 3 index_y set, 4 index_y test
  task automatic run(input int kind, input logic [2:0] b, r, input logic [7:0] d);
    ea = (kind == 1) ? pointer_pair_in : ((kind == 2) ? index_x_in : index_y_in) + {{8{d[7]}}, d};
    mdl.mem[ea] = 8'($urandom);
    pre = (kind == 0) ? regs[r] : mdl.mem[ea];
    st = 8'($urandom);
    status_byte_in <= st;
    k = 0;
    send((kind == 2) ? `PFX_INDEX_X : ((kind > 2) ? `PFX_INDEX_Y : `PFX_CB));
    k0 = k;
    if (kind > 1) send(`PFX_CB);
    if (kind > 1) send(d);
    send({(kind == 4) ? `OP_GRP_TEST : `OP_GRP_SET, b, (kind == 0) ? r : `REG_CODE_MEM});
    fetch_vld_in <= 1'b0;
    while (done_out !== 1'b1 && k < k0 + 60) begin
      @(posedge core_clk_in);
      #1;
      k++;
    end
    cmp8(8'(k - k0), (kind == 0) ? 8'h08 : (kind == 1) ? 8'h0f : (kind == 4) ? 8'h14 : 8'h17);
    if (kind == 0) cmp8(regs[r], pre | (8'h01 << b));
    else cmp8(mdl.mem[ea], (kind == 4) ? pre : pre | (8'h01 << b));
    st = {st[7], ~pre[b], 1'b0, 1'b1, 1'b0, st[2], 1'b0, st[0]};
    if (kind == 4) cmp8(status_byte_reg_out & 8'hd7, st);
    @(posedge core_clk_in);
  endtask
  initial begin
    rst_b_in = 1'b0;
    fetch_vld_in = 1'b0;
    fetch_byte_in = 8'h00;
    status_byte_in = 8'h00;
    index_x_in = 16'h2000;
    index_y_in = 16'h2000;
    pointer_pair_in = 16'h3000;
    void'($urandom(32'h4fc3));
    foreach (regs[i]) regs[i] = 8'($urandom);
    repeat (20) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    run(3, 3'h0, 3'h0, 8'h03);
    run(2, 3'h7, 3'h0, 8'h80);
    run(4, 3'h6, 3'h0, 8'h7f);
    run(1, 3'h7, 3'h0, 8'h00);
    run(0, 3'h0, 3'h7, 8'h00);
    // prefix without CB, then an unsupported CB op, both dropped
    send(`PFX_INDEX_Y);
    send(8'h00);
    send(`PFX_CB);
    send(8'h86);
    fetch_vld_in <= 1'b0;
    repeat (30) @(posedge core_clk_in);
    cmp8({7'h00, fetch_rdy_out}, 8'h01);
    run(0, 3'h3, 3'h1, 8'h00);
    for (int i = 0; i < 60; i++) begin
      index_x_in <= 16'($urandom);
      index_y_in <= 16'($urandom);
      pointer_pair_in <= 16'($urandom);
      @(posedge core_clk_in);
      j = $urandom_range(0, 6);
      run($urandom_range(0, 4), 3'($urandom), (j == 6) ? 3'h7 : 3'(j), 8'($urandom));
    end
    end_sim();
  end
endmodule // bit_test_set_unit_tb
